// [design/pisel_ctrl.sv]
/*
 * pisel_ctrl: input selection and holdover control for one loop, with its
 * register file on an AHB-Lite slave.
 * assumes: fault pins and freq samples come from other clock domains and are
 * synchronised here; single word transfers only; one clock.
 */
// Local design decision: the AHB-Lite slave port.
// What this block does
// - force-holdover bit holds output: holdover with valid history, else freerun
// - switch-mode field: 0 manual, 1 auto non-revertive, 2 auto revertive
// - hitless-enable bit turns on phase buildout for input switches
// - absent-clock mask bit per input drops that fault from auto validity
// - frequency-offset mask bit per input drops that fault from auto validity
// - auto modes pick the valid input with the best rank; non-revertive only once the current input fails
// - rank 0 is never auto-selected but still manually selectable
// - rank ties go to the lowest input index
// - holdover uses history delayed by programmed delay, skipping recent samples
// - holdover count, phase threshold, coarse length held as little-endian bytes
// - selection outcome, faults masked, can drive holdover entry
// - history valid reads 1 once enough history accumulated, else 0
// - manual selection field picks input 0-3; 4-7 reserved
module pisel_ctrl (
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic                        ce,
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic      [31:0]                 hrdata,
    output logic                             hreadyout,
    output logic                             hresp,
    input  wire pisel_pkg::pisel_faults_type faults_pin,
    input  wire logic [7:0]                  freq_sample,
    input  wire logic                        freq_sample_valid,
    output pisel_pkg::pisel_status_type      status,
    output logic      [7:0]                  holdover_freq,
    output logic      [23:0]                 holdover_cycle_count,
    output logic      [9:0]                  hitless_phase_threshold,
    output logic      [4:0]                  hitless_coarse_length
);
    import pisel_pkg::*;

    // rank decode, used for every input and the current one
    function automatic logic rank_usable(input logic [2:0] r);
        return (r != RANK_NEVER) && (r <= RANK_WORST);
    endfunction : rank_usable

    // register file
    logic [7:0] regs [NUM_REGS];
    logic [7:0] next_regs [NUM_REGS];
    logic [11:0] ap_idx;
    logic       ap_write;
    logic       ap_valid;
    logic [11:0] next_ap_idx;
    logic       next_ap_write;
    logic       next_ap_valid;
    logic [31:0] next_hrdata;

    // synchronisers
    pisel_faults_type flt_s1, flt_s2;
    logic [7:0] fs_s1, fs_s2;
    logic       fv_s1, fv_s2, fv_s3;

    // selection / loop state
    pisel_state_type state, next_state;
    logic [1:0]  active, next_active;
    logic [15:0] hist_cnt, next_hist_cnt;
    logic [2:0]  wr_ptr, next_wr_ptr;
    logic [7:0]  next_holdover_freq;
    logic [7:0]  mem_rd;
    logic [2:0]  rd_ptr;

    logic [3:0] in_valid;
    logic [2:0] rank [NUM_INPUTS];
    logic       best_found;
    logic [1:0] best_idx;
    logic [2:0] best_rank;
    logic [1:0] want_input;
    logic       want_ok;
    logic       hist_valid;
    logic [4:0] hist_delay;

    function automatic int reg_slot(input logic [11:0] idx);
        case (idx)
            IDX_HOLD_CNT_LO:  return 0;
            IDX_HOLD_CNT_MID: return 1;
            IDX_HOLD_CNT_HI:  return 2;
            IDX_FORCE_HOLD:   return 3;
            IDX_SWITCH_CTRL:  return 4;
            IDX_FAULT_MASKS:  return 5;
            IDX_PRIO_LO:      return 6;
            IDX_PRIO_HI:      return 7;
            IDX_HSW_MODE:     return 8;
            IDX_PH_THR_LO:    return 9;
            IDX_PH_THR_HI:    return 10;
            IDX_COARSE_LEN:   return 11;
            IDX_HIST_DELAY:   return 12;
            IDX_STATUS:       return 13;
            default:          return -1;
        endcase
    endfunction : reg_slot

    // bus: zero wait states, always OKAY
    always_comb begin
        next_ap_valid = hsel && hready && htrans[1];
        next_ap_write = hwrite;
        next_ap_idx   = haddr[13:2];
        if (!(hsel && hready)) begin
            next_ap_valid = 1'b0;
            next_ap_write = 1'b0;
            next_ap_idx   = ap_idx;
        end
    end

    always_comb begin
        int s;
        s = reg_slot(next_ap_idx);
        next_hrdata = 32'h0;
        if (next_ap_valid && !next_ap_write && s >= 0) begin
            if (s == 13) begin
                next_hrdata[HIST_VAL_BIT] = hist_valid;
            end else begin
                next_hrdata[7:0] = regs[s];
            end
        end
    end

    always_comb begin
        int s;
        s = reg_slot(ap_idx);
        for (int i = 0; i < NUM_REGS; i++) begin
            next_regs[i] = regs[i];
        end
        // status slot is read-only; unmapped writes are dropped
        if (ap_valid && ap_write && s >= 0 && s != 13) begin
            next_regs[s] = hwdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ap_idx   <= 12'h0;
            ap_write <= 1'b0;
            ap_valid <= 1'b0;
            hrdata   <= 32'h0;
            for (int i = 0; i < NUM_REGS; i++) begin
                regs[i] <= (i == 8) ? RST_HSW_MODE : RST_ZERO;
            end
        end else if (ce) begin
            ap_idx   <= next_ap_idx;
            ap_write <= next_ap_write;
            ap_valid <= next_ap_valid;
            hrdata   <= next_hrdata;
            for (int i = 0; i < NUM_REGS; i++) begin
                regs[i] <= next_regs[i];
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // pins cross in from the reference domains
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flt_s1 <= '0;
            flt_s2 <= '0;
            fs_s1  <= 8'h00;
            fs_s2  <= 8'h00;
            fv_s1  <= 1'b0;
            fv_s2  <= 1'b0;
            fv_s3  <= 1'b0;
        end else if (ce) begin
            flt_s1 <= faults_pin;
            flt_s2 <= flt_s1;
            fs_s1  <= freq_sample;
            fs_s2  <= fs_s1;
            fv_s1  <= freq_sample_valid;
            fv_s2  <= fv_s1;
            fv_s3  <= fv_s2;
        end
    end

    // per-input validity and rank
    genvar g;
    generate
        for (g = 0; g < NUM_INPUTS; g++) begin : g_in
            logic [7:0] prio_byte;
            assign prio_byte = regs[6 + g / 2];
            assign rank[g] = (g % 2 == 0) ? prio_byte[PRIO_A_LSB +: 3]
                                          : prio_byte[PRIO_B_LSB +: 3];
            assign in_valid[g] =
                (!flt_s2.clock_absent_fault[g] || regs[5][LOS_MSK_LSB + g]) &&
                (!flt_s2.frequency_offset_fault[g] || regs[5][OOF_MSK_LSB + g]);
        end
    endgenerate

    // best-rank search; strict compare keeps the lowest index on ties
    always_comb begin
        best_found = 1'b0;
        best_idx   = 2'h0;
        best_rank  = RANK_WORST;
        for (int i = 0; i < NUM_INPUTS; i++) begin
            if (in_valid[i] && rank_usable(rank[i]) &&
                (!best_found || rank[i] < best_rank)) begin
                best_found = 1'b1;
                best_idx   = 2'(i);
                best_rank  = rank[i];
            end
        end
    end

    always_comb begin
        want_input = active;
        want_ok    = 1'b0;
        case (regs[4][MODE_LSB +: 2])
            SW_MANUAL: begin
                // reserved selection values 4-7 keep the current input
                if (regs[3][3:2] == 2'h0) begin
                    want_input = regs[3][5:4];
                end
                want_ok = in_valid[want_input];
            end
            SW_AUTO_NONREV: begin
                if (in_valid[active] && rank_usable(rank[active])) begin
                    want_input = active;
                    want_ok    = 1'b1;
                end else begin
                    want_input = best_found ? best_idx : active;
                    want_ok    = best_found;
                end
            end
            SW_AUTO_REV: begin
                want_input = best_found ? best_idx : active;
                want_ok    = best_found;
            end
            default: begin
                want_input = active;
                want_ok    = in_valid[active];
            end
        endcase
    end

    assign hist_valid = (hist_cnt >= HIST_MIN_CYCLES);
    assign hist_delay = regs[12][4:0];

    // loop state: forced hold wins, then selection outcome decides
    always_comb begin
        next_state  = state;
        next_active = active;
        case (state)
            PISEL_LOCKED: begin
                if (regs[3][0] || !want_ok || want_input != active) begin
                    next_state = hist_valid ? PISEL_HOLDOVER : PISEL_FREERUN;
                end
            end
            PISEL_HOLDOVER, PISEL_FREERUN: begin
                if (!regs[3][0] && want_ok) begin
                    next_state  = PISEL_LOCKED;
                    next_active = want_input;
                end
            end
            default: begin
                next_state = PISEL_FREERUN;
            end
        endcase
    end

    // history accumulates only while locked; cleared on relock
    always_comb begin
        next_hist_cnt = hist_cnt;
        next_wr_ptr   = wr_ptr;
        if (state != PISEL_LOCKED) begin
            next_hist_cnt = (next_state == PISEL_LOCKED) ? 16'h0 : hist_cnt;
        end else if (!hist_valid && next_state == PISEL_LOCKED) begin
            // no count on the leaving edge, so a forced exit sees a settled history_valid
            next_hist_cnt = hist_cnt + 16'h1;
        end
        if (state == PISEL_LOCKED && fv_s2 && !fv_s3) begin
            next_wr_ptr = wr_ptr + 3'h1;
        end
    end

    // delay clipped to 6; larger settings read seven writes back, the slot next to the oldest
    assign rd_ptr = wr_ptr - 3'h1 - ((hist_delay > 5'h6) ? 3'h6 : hist_delay[2:0]);

    always_comb begin
        next_holdover_freq = holdover_freq;
        if (state == PISEL_LOCKED) begin
            next_holdover_freq = mem_rd;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state         <= PISEL_FREERUN;
            active        <= 2'h0;
            hist_cnt      <= 16'h0;
            wr_ptr        <= 3'h0;
            holdover_freq <= 8'h00;
        end else if (ce) begin
            state         <= next_state;
            active        <= next_active;
            hist_cnt      <= next_hist_cnt;
            wr_ptr        <= next_wr_ptr;
            holdover_freq <= next_holdover_freq;
        end
    end

    pisel_hist_mem u_hist (
        .clk     (clk),
        .rstn    (rstn),
        .ce      (ce),
        .wr_en   (state == PISEL_LOCKED && fv_s2 && !fv_s3),
        .wr_addr (wr_ptr),
        .wr_data (fs_s2),
        .rd_addr (rd_ptr),
        .rd_data (mem_rd)
    );

    assign status.active_input   = active;
    assign status.input_ok       = want_ok;
    assign status.phase_buildout = regs[4][HSW_EN_BIT];
    assign status.loop_state     = state;
    assign status.history_valid  = hist_valid;

    // hitless mode fields are passed through as written; software keeps 1 / 0
    assign holdover_cycle_count    = {regs[2], regs[1], regs[0]};
    assign hitless_phase_threshold = {regs[10][1:0], regs[9]};
    assign hitless_coarse_length   = regs[11][4:0];
endmodule : pisel_ctrl

// [design/pisel_pkg.sv]
/*
 * pisel_pkg: register map, field positions, reset values and carrier types
 * for the loop input-select and holdover controller.
 * assumes: AHB-Lite slave, 32-bit data, one register per aligned word.
 */
package pisel_pkg;
    // printed offsets are not word multiples: kept as indices, byte address = 4 * index
    localparam logic [11:0] IDX_HOLD_CNT_LO  = 12'h733;
    localparam logic [11:0] IDX_HOLD_CNT_MID = 12'h734;
    localparam logic [11:0] IDX_HOLD_CNT_HI  = 12'h735;
    localparam logic [11:0] IDX_FORCE_HOLD   = 12'h736;
    localparam logic [11:0] IDX_SWITCH_CTRL  = 12'h737;
    localparam logic [11:0] IDX_FAULT_MASKS  = 12'h738;
    localparam logic [11:0] IDX_PRIO_LO      = 12'h739;
    localparam logic [11:0] IDX_PRIO_HI      = 12'h73a;
    localparam logic [11:0] IDX_HSW_MODE     = 12'h73b;
    localparam logic [11:0] IDX_PH_THR_LO    = 12'h73c;
    localparam logic [11:0] IDX_PH_THR_HI    = 12'h73d;
    localparam logic [11:0] IDX_COARSE_LEN   = 12'h73e;
    localparam logic [11:0] IDX_HIST_DELAY   = 12'h730;
    localparam logic [11:0] IDX_STATUS       = 12'h740;

    localparam int NUM_INPUTS   = 4;
    localparam int NUM_REGS     = 14;
    localparam int MODE_LSB     = 0;
    localparam int HSW_EN_BIT   = 2;
    localparam int LOS_MSK_LSB  = 0;
    localparam int OOF_MSK_LSB  = 4;
    localparam int PRIO_A_LSB   = 0;
    localparam int PRIO_B_LSB   = 4;
    localparam int HIST_VAL_BIT = 1;

    localparam logic [1:0] SW_MANUAL      = 2'h0;
    localparam logic [1:0] SW_AUTO_NONREV = 2'h1;
    localparam logic [1:0] SW_AUTO_REV    = 2'h2;

    localparam logic [2:0] RANK_NEVER = 3'h0;
    localparam logic [2:0] RANK_WORST = 3'h4;

    localparam logic [7:0] RST_HSW_MODE = 8'h01;
    localparam logic [7:0] RST_ZERO     = 8'h00;

    // history must accumulate this long before holdover is allowed
    localparam int          HIST_MIN_US     = 10;
    localparam int          CLK_MHZ         = 100;
    localparam logic [15:0] HIST_MIN_CYCLES = 16'(HIST_MIN_US * CLK_MHZ);
    // history ring depth in samples; each delay step reads one slot further back
    localparam int          HIST_DEPTH      = 8;

    typedef enum logic [2:0] {
        PISEL_LOCKED   = 3'b001,
        PISEL_HOLDOVER = 3'b010,
        PISEL_FREERUN  = 3'b100
    } pisel_state_type;

    typedef struct packed {
        logic [3:0] clock_absent_fault;
        logic [3:0] frequency_offset_fault;
    } pisel_faults_type;

    typedef struct packed {
        logic [1:0]      active_input;
        logic            input_ok;
        logic            phase_buildout;
        pisel_state_type loop_state;
        logic            history_valid;
    } pisel_status_type;
endpackage : pisel_pkg

// [design/pisel_hist_mem.sv]
/*
 * pisel_hist_mem: small ring of recent frequency samples used by holdover.
 * assumes: one write per sample, read data registered, same clock as caller.
 */
module pisel_hist_mem (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       ce,
    input  wire logic       wr_en,
    input  wire logic [2:0] wr_addr,
    input  wire logic [7:0] wr_data,
    input  wire logic [2:0] rd_addr,
    output logic      [7:0] rd_data
);
    import pisel_pkg::*;
    logic [7:0] mem [HIST_DEPTH];
    logic [7:0] next_rd_data;

    always_comb begin
        next_rd_data = mem[rd_addr];
    end

    always_ff @(posedge clk) begin
        if (ce && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_data <= 8'h00;
        end else if (ce) begin
            rd_data <= next_rd_data;
        end
    end
endmodule : pisel_hist_mem

// [dv/pisel_refclk_model.sv]
/* pisel_refclk_model: the four reference inputs behind the selector.
   assumes: the bench sets fault levels on fault_cmd; one clock. */
module pisel_refclk_model (
    input  wire logic                        clk,
    input  wire pisel_pkg::pisel_faults_type fault_cmd,
    output pisel_pkg::pisel_faults_type      faults_pin,
    output logic [7:0]                       freq_sample,
    output logic                             freq_sample_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    import pisel_pkg::*;
    logic [7:0] next_freq = 8'h80;
    int         tick      = 0;
    initial begin
        freq_sample = 8'h00;
        freq_sample_valid = 1'b0;
    end
    // faults come from an unrelated source, so they move off the edge
    assign #3 faults_pin = fault_cmd;
    always @(posedge clk) begin
        tick <= tick + 1;
        freq_sample_valid <= (tick % 8) < 2;
        if ((tick % 8) == 0) begin
            next_freq <= next_freq + 8'h01;
            freq_sample <= next_freq;
        end else if ((tick % 8) == 2) begin
            // outside a sample the line holds no trustworthy value
            freq_sample <= ~freq_sample;
        end
    end
endmodule : pisel_refclk_model

// [dv/pisel_ctrl_assertions.sv]
/* pisel_ctrl_assertions: port checks on the input selector, with a shadow of
   the register map built from the bus.
   assumes: bound to pisel_ctrl; one clock, rstn async active low. */
module pisel_ctrl_assertions (
    input wire logic                        clk,
    input wire logic                        rstn,
    input wire logic                        ce,
    input wire logic                        hsel,
    input wire logic [31:0]                 haddr,
    input wire logic [1:0]                  htrans,
    input wire logic                        hwrite,
    input wire logic [31:0]                 hwdata,
    input wire logic                        hready,
    input wire logic [31:0]                 hrdata,
    input wire logic                        hreadyout,
    input wire logic                        hresp,
    input wire pisel_pkg::pisel_faults_type faults_pin,
    input wire pisel_pkg::pisel_status_type status,
    input wire logic [23:0]                 holdover_cycle_count,
    input wire logic [9:0]                  hitless_phase_threshold,
    input wire logic [4:0]                  hitless_coarse_length
);
    import pisel_pkg::*;
    logic [7:0]       regs [0:16];
    logic             pend_wr;
    logic [11:0]      pend_idx;
    logic [9:0]       lock_run;
    logic [3:0]       age;
    pisel_faults_type flt_q;
    wire  [11:0]      idx    = haddr[13:2];
    wire  [1:0]       mode   = regs[7][1:0];
    wire  [1:0]       act    = status.active_input;
    wire  [7:0]       prio   = regs[9 + act[1]];
    wire  [2:0]       rank   = act[0] ? prio[6:4] : prio[2:0];
    wire              locked = status.loop_state == PISEL_LOCKED;
    wire              quiet  = age > 4'hc;
    wire              none_ok = &((faults_pin.clock_absent_fault & ~regs[8][3:0])
                                | (faults_pin.frequency_offset_fault & ~regs[8][7:4]));
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 17; i++) regs[i] <= (i == 11) ? RST_HSW_MODE : 8'h00;
            pend_wr <= 1'b0;
            pend_idx <= 12'h000;
            lock_run <= 10'h000;
            age <= 4'h0;
            flt_q <= '0;
        end else if (ce) begin
            pend_wr <= hsel && hready && htrans[1] && hwrite;
            pend_idx <= idx;
            flt_q <= faults_pin;
            if (pend_wr && pend_idx >= 12'h730 && pend_idx <= 12'h73e) begin
                regs[pend_idx - 12'h730] <= hwdata[7:0];
            end
            // any write or fault change restarts the settling window
            age <= (pend_wr || faults_pin != flt_q) ? 4'h0 : age + {3'h0, age != 4'hf};
            lock_run <= locked ? lock_run + {9'h0, lock_run != 10'h3ff} : 10'h000;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence rd_status_s;
        hsel && hready && htrans[1] && !hwrite && idx == IDX_STATUS;
    endsequence
    sequence forced_s;
        regs[6][0] [*3];
    endsequence
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not zero-wait okay");
    force_hold_a: assert property (forced_s |-> status.loop_state ==
        (status.history_valid ? PISEL_HOLDOVER : PISEL_FREERUN))
        else $error("forced loop not in holdover or freerun");
    params_a: assert property (holdover_cycle_count == {regs[5], regs[4], regs[3]}
        && hitless_phase_threshold == {regs[13][1:0], regs[12]}
        && hitless_coarse_length == regs[14][4:0]) else $error("parameter outputs differ");
    hitless_gate_a: assert property (status.phase_buildout == regs[7][2])
        else $error("phase buildout differs from hitless enable");
    hist_read_a: assert property (rd_status_s
        |=> hrdata[1] == $past(status.history_valid))
        else $error("status read history bit wrong");
    hist_time_a: assert property ($rose(status.history_valid)
        |-> lock_run >= HIST_MIN_CYCLES - 3) else $error("history valid too early");
    rank_never_a: assert property (quiet && (mode[0] ^ mode[1]) && locked
        |-> rank != RANK_NEVER) else $error("rank zero input auto selected");
    // reserved selection codes keep the current input, so they are left out
    manual_sel_a: assert property (quiet && mode == SW_MANUAL && locked
        && regs[6][3:2] == 2'h0 |-> act == regs[6][5:4])
        else $error("manual selection not followed");
    no_valid_a: assert property (quiet && (mode[0] ^ mode[1]) && none_ok
        |-> !locked) else $error("locked with no valid input");
endmodule : pisel_ctrl_assertions
bind pisel_ctrl pisel_ctrl_assertions i_chk (.*);

// [dv/tb.sv]
/* tb: register-level test of the input selector with a reference-clock model.
   assumes: 100 MHz clock, zero-wait AHB-Lite single word transfers. */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pisel_pkg::*;
    logic             clk = 1'b0, rstn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0]      haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0]       htrans = 2'h0;
    logic [2:0]       hsize = 3'h2;
    logic             hready, hreadyout, hresp, freq_sample_valid;
    logic [7:0]       freq_sample, holdover_freq, hf;
    logic [23:0]      holdover_cycle_count;
    logic [9:0]       hitless_phase_threshold;
    logic [4:0]       hitless_coarse_length;
    pisel_faults_type fault_cmd = '0, faults_pin;
    pisel_status_type status;
    int               miscompares = 0, check_count = 0, cycles = 0;
    assign hready = hreadyout;
    pisel_ctrl i_dut (.*);
    pisel_refclk_model i_ref (.*);
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {18'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic rdchk(input string what, input logic [11:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00);
        check(what, rd, exp);
    endtask : rdchk
    // waits a bounded time for the state, then compares it
    task automatic expect_st(input string what, input pisel_state_type st, input logic [1:0] inp);
        int n;
        n = 0;
        while (!(status.loop_state === st && (st !== PISEL_LOCKED
               || status.active_input === inp)) && n < 60) begin
            @(negedge clk);
            n++;
        end
        check(what, 32'(status.loop_state), 32'(st));
        if (st === PISEL_LOCKED) check(what, 32'(status.active_input), 32'(inp));
    endtask : expect_st
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        for (logic [11:0] i = 12'h733; i <= 12'h73e; i++) begin
            rdchk("reset value", i, (i == IDX_HSW_MODE) ? 32'h1 : 32'h0);
        end
        rdchk("unmapped", 12'h7ff, 32'h0);
        // software only ever writes the fixed hitless mode setting back
        bus(1'b1, IDX_HSW_MODE, 8'h01);
        rdchk("hitless mode kept", IDX_HSW_MODE, 32'h1);
        bus(1'b1, IDX_HOLD_CNT_LO, 8'h11);
        bus(1'b1, IDX_HOLD_CNT_MID, 8'h22);
        bus(1'b1, IDX_HOLD_CNT_HI, 8'h33);
        bus(1'b1, IDX_PH_THR_LO, 8'ha5);
        bus(1'b1, IDX_PH_THR_HI, 8'h03);
        bus(1'b1, IDX_COARSE_LEN, 8'h1f);
        // the last write lands on the edge the task returns at
        @(negedge clk);
        check("cycle count", 32'(holdover_cycle_count), 32'h332211);
        check("threshold", 32'(hitless_phase_threshold), 32'h3a5);
        check("coarse", 32'(hitless_coarse_length), 32'h1f);
        // all ranks are zero here, so manual picks a never-auto input
        bus(1'b1, IDX_FORCE_HOLD, 8'h20);
        expect_st("manual", PISEL_LOCKED, 2'h2);
        bus(1'b1, IDX_FORCE_HOLD, 8'h21);
        expect_st("force no history", PISEL_FREERUN, 2'h0);
        bus(1'b1, IDX_FORCE_HOLD, 8'h20);
        expect_st("relock", PISEL_LOCKED, 2'h2);
        for (int n = 0; n < 1200 && status.history_valid !== 1'b1; n++) @(negedge clk);
        bus(1'b0, IDX_STATUS, 8'h00);
        check("history valid", {31'h0, rd[HIST_VAL_BIT]}, 32'h1);
        // model sends one sample per eight ticks; late in the period the newest is settled
        bus(1'b1, IDX_HIST_DELAY, 8'h03);
        repeat (4) @(negedge clk);
        while (i_ref.tick % 8 != 7) @(negedge clk);
        hf = i_ref.next_freq - 8'h04;
        check("delayed history", 32'(holdover_freq), 32'(hf));
        bus(1'b1, IDX_FORCE_HOLD, 8'h21);
        expect_st("force holdover", PISEL_HOLDOVER, 2'h0);
        hf = holdover_freq;
        repeat (30) @(negedge clk);
        check("frozen freq", 32'(holdover_freq), 32'(hf));
        bus(1'b1, IDX_FORCE_HOLD, 8'h20);
        bus(1'b1, IDX_PRIO_LO, 8'h20);
        bus(1'b1, IDX_PRIO_HI, 8'h12);
        bus(1'b1, IDX_SWITCH_CTRL, {6'h0, SW_AUTO_REV});
        expect_st("best rank", PISEL_LOCKED, 2'h3);
        fault_cmd <= '{4'h8, 4'h0};
        expect_st("tie lowest", PISEL_LOCKED, 2'h1);
        bus(1'b1, IDX_FAULT_MASKS, 8'h08);
        expect_st("absent masked", PISEL_LOCKED, 2'h3);
        fault_cmd <= '{4'h0, 4'h8};
        bus(1'b1, IDX_FAULT_MASKS, 8'h00);
        expect_st("offset used", PISEL_LOCKED, 2'h1);
        bus(1'b1, IDX_FAULT_MASKS, 8'h80);
        expect_st("offset masked", PISEL_LOCKED, 2'h3);
        bus(1'b1, IDX_FAULT_MASKS, 8'h00);
        expect_st("revert away", PISEL_LOCKED, 2'h1);
        bus(1'b1, IDX_SWITCH_CTRL, {6'h1, SW_AUTO_NONREV});
        rdchk("hitless on", IDX_SWITCH_CTRL, 32'h5);
        check("buildout on", 32'(status.phase_buildout), 32'h1);
        fault_cmd <= '0;
        repeat (40) @(negedge clk);
        expect_st("non revertive", PISEL_LOCKED, 2'h1);
        fault_cmd <= '{4'h2, 4'h0};
        expect_st("leave failed", PISEL_LOCKED, 2'h3);
        bus(1'b1, IDX_SWITCH_CTRL, 8'h03);
        fault_cmd <= '0;
        repeat (40) @(negedge clk);
        expect_st("reserved mode", PISEL_LOCKED, 2'h3);
        check("buildout off", 32'(status.phase_buildout), 32'h0);
        bus(1'b1, IDX_SWITCH_CTRL, {6'h0, SW_AUTO_REV});
        fault_cmd <= '{4'hf, 4'h0};
        repeat (20) @(negedge clk);
        check("no valid input", {31'h0, status.loop_state === PISEL_LOCKED}, 32'h0);
        check("input ok low", 32'(status.input_ok), 32'h0);
        bus(1'b1, IDX_FAULT_MASKS, 8'h0f);
        expect_st("all masked", PISEL_LOCKED, 2'h3);
        check("input ok high", 32'(status.input_ok), 32'h1);
        final_report();
    end
endmodule : tb
